// File: sfs_pkg.sv
/*
 Constants, opcodes, register map and types for the SPI memory slave front end.
 Assumes a 125 MHz system clock and an SPI master that runs at 20 MHz or slower.
*/
package sfs_pkg;
	localparam int ADDR_W = 19;
	localparam int MEM_DEPTH = 524288;
	localparam int SPECIAL_DEPTH = 256;
	localparam int SERIAL_BYTES = 8;
	localparam int ADDR_BYTES = 3;
	localparam int APB_AW = 12;

	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE_CMD = 8'h04;
	localparam logic [7:0] OP_RDSR = 8'h05;
	localparam logic [7:0] OP_WRSR = 8'h01;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_WRITE = 8'h02;
	localparam logic [7:0] OP_SSWR = 8'h42;
	localparam logic [7:0] OP_SSRD = 8'h4b;
	localparam logic [7:0] OP_RDID = 8'h9f;
	localparam logic [7:0] OP_RUID = 8'h4c;
	localparam logic [7:0] OP_WRSN = 8'hc2;
	localparam logic [7:0] OP_RDSN = 8'hc3;

	localparam int ST_PROTECT_PIN_ENABLE_BIT = 7;
	localparam int ST_BP_LSB = 2;
	localparam int ST_WEL_BIT = 1;
	localparam logic [1:0] BP_RST = 2'h0;

	localparam logic [APB_AW-1:0] REG_CTRL = 12'h000;
	localparam logic [APB_AW-1:0] REG_STAT = 12'h004;
	localparam logic [APB_AW-1:0] REG_WRCNT = 12'h008;
	localparam int CTRL_LOCK_BIT = 0;
	localparam int STAT_SEL_BIT = 8;

	localparam longint PCLK_HZ = 125000000;
	localparam longint SCK_MAX_HZ = 20000000;
	localparam int SCK_HALF_CYC = int'(PCLK_HZ / (2 * SCK_MAX_HZ));
	localparam int SYNC_LAT_CYC = 2;

	typedef enum logic [2:0] {
		ST_OPC = 3'b000,
		ST_ADDR = 3'b001,
		ST_WR = 3'b010,
		ST_RD = 3'b011,
		ST_WRSR = 3'b100,
		ST_DROP = 3'b101
	} sfs_state_type;

	typedef enum logic [1:0] {
		SP_MAIN = 2'b00,
		SP_SPECIAL = 2'b01,
		SP_SERIAL = 2'b10
	} sfs_space_type;
endpackage

// File: sfs_mem_if.sv
/*
 Write and read port between the SPI front end and its storage.
 Assumes the controller drives all requests from flip-flops on clk.
*/
`timescale 1ns/1ns
interface sfs_mem_if (
	input wire logic clk
);
	logic we;
	sfs_pkg::sfs_space_type space;
	logic [sfs_pkg::ADDR_W-1:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport ctl (output we, output space, output addr, output wdata, input rdata);
	modport mem (input clk, input we, input space, input addr, input wdata, output rdata);
endinterface

// File: sfs_store.sv
/*
 Byte storage: main array, special sector and serial number bytes.
 Assumes one write strobe per byte; reads are combinational from the address.
*/
`timescale 1ns/1ns
module sfs_store
	import sfs_pkg::*;
#(
	parameter int DEPTH = MEM_DEPTH
) (
	sfs_mem_if.mem m
);
	localparam int AW = $clog2(DEPTH);

	logic [7:0] main_mem [DEPTH];
	logic [7:0] spec_mem [SPECIAL_DEPTH];
	logic [7:0] serial_mem [SERIAL_BYTES];

	// Whole-byte locations only
	always_ff @(posedge m.clk) begin // R10
		if (m.we) begin
			case (m.space)
				SP_MAIN: main_mem[m.addr[AW-1:0]] <= m.wdata;
				SP_SPECIAL: spec_mem[m.addr[7:0]] <= m.wdata;
				SP_SERIAL: serial_mem[m.addr[2:0]] <= m.wdata;
				default: ;
			endcase
		end
	end

	always_comb begin
		case (m.space)
			SP_MAIN: m.rdata = main_mem[m.addr[AW-1:0]];
			SP_SPECIAL: m.rdata = spec_mem[m.addr[7:0]];
			SP_SERIAL: m.rdata = serial_mem[m.addr[2:0]];
			default: m.rdata = 8'h00;
		endcase
	end
endmodule

// File: sfs_slave.sv
/*
 SPI slave front end of a byte-wide nonvolatile memory, with an APB status port.
 Assumes SPI pins are asynchronous to pclk and the SPI clock runs at most 20 MHz,
 so each SPI clock level lasts at least three pclk cycles.
*/
// Added by the designer: the placing of the registers and the APB slave port.
// How it works
// R1: Select high means standby: inputs ignored, serial output released.
// R2: Master drops select before every opcode; each command starts a new frame.
// R3: Input bits taken on clock rise, output bits changed on clock fall.
// R4: Clock from zero to 20 MHz, may pause; transfer state is kept.
// R5: Serial input matters only at clock rising edges.
// R6: Serial output driven only while a read returns data.
// R7: Protect-pin-enable set and write-protect low refuses status writes.
// R8: Each received data byte is written at once after its last bit.
// R9: Works in SPI modes 0 and 3 only.
// R10: Array holds 512K byte locations; transfers are whole bytes.
// R11: Block protection guards top quarter, top half or whole array.
// R12: Separate 256-byte special sector with its own write and read commands.
// R13: Read-only ID values plus 8-byte writable and readable serial number.
// R14: Write-disable command refuses memory writes until writing re-enabled.
// R15: Input and output may share one wire; output drives only in reads.
// R16: Three address bytes follow the opcode; only low 19 bits used.
// R17: First byte after select falls is the opcode.
// R18: Unknown opcode: ignore the rest of the frame, output stays released.
// R19: All bytes move most significant bit first, both directions.
// R20: Write-enable latch cleared by write-disable blocks all writes.
`timescale 1ns/1ns
module sfs_slave
	import sfs_pkg::*;
#(
	parameter int DEPTH = sfs_pkg::MEM_DEPTH,
	parameter logic [31:0] DEV_ID = 32'h5a01_0203, // arbitrary value
	parameter logic [63:0] UNIQUE_ID = 64'h0011_2233_4455_6677 // arbitrary value
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sfs_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic wp_n,
	output logic so,
	output logic so_oe_n
);
	import sfs_pkg::*;

	if (DEPTH > (1 << ADDR_W) || DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk_depth
		$error("DEPTH must be a power of two up to the 19-bit address space");
	end
	if (SCK_HALF_CYC <= SYNC_LAT_CYC) begin : g_chk_rate
		$error("pclk too slow to sample the SPI clock");
	end

	localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(DEPTH - 1);
	localparam logic [ADDR_W-1:0] HALF_ADDR = ADDR_W'(DEPTH / 2);
	localparam logic [ADDR_W-1:0] QUARTER3_ADDR = ADDR_W'(DEPTH - DEPTH / 4);

	function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
		input sfs_space_type sp);
		logic [ADDR_W-1:0] n;
		n = a + 1'b1;
		case (sp)
			SP_MAIN: next_addr = n & LAST_ADDR;
			SP_SPECIAL: next_addr = {11'h000, n[7:0]};
			SP_SERIAL: next_addr = {16'h0000, n[2:0]};
			default: next_addr = n;
		endcase
	endfunction

	function automatic logic is_protected(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
		case (bp)
			2'h1: is_protected = a >= QUARTER3_ADDR;
			2'h2: is_protected = a >= HALF_ADDR;
			2'h3: is_protected = 1'b1;
			default: is_protected = 1'b0;
		endcase
	endfunction

	logic cs_m, cs_s, sck_m, sck_s, sck_d, si_m, si_s, wp_m, wp_s;
	logic [2:0] bit_cnt_r;
	logic [6:0] shift_r;
	sfs_state_type state_r;
	logic [7:0] opc_r;
	logic [1:0] addr_cnt_r;
	logic [ADDR_W-1:0] addr_r;
	sfs_space_type space_r;
	logic load_pend_r;
	logic wel_r, protect_pin_enable_r;
	logic [1:0] bp_r;
	logic mem_we_r;
	logic [7:0] mem_wdata_r;
	logic [7:0] tx_r;
	logic [31:0] wr_cnt_r;
	logic lock_r;
	logic selected, rise, fall, byte_done, wr_ok;
	logic [7:0] rx_byte, status_byte, tx_src;

	sfs_mem_if mif (.clk(pclk));
	sfs_store #(.DEPTH(DEPTH)) u_store (.m(mif.mem));

	assign mif.we = mem_we_r;
	assign mif.space = space_r;
	assign mif.addr = addr_r;
	assign mif.wdata = mem_wdata_r;

	// All pins pass two flops; sck_d only sees the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cs_m <= 1'b1;
			cs_s <= 1'b1;
			sck_m <= 1'b0;
			sck_s <= 1'b0;
			sck_d <= 1'b0;
			si_m <= 1'b0;
			si_s <= 1'b0;
			wp_m <= 1'b1;
			wp_s <= 1'b1;
		end else begin
			cs_m <= cs_n;
			cs_s <= cs_m;
			sck_m <= sck;
			sck_s <= sck_m;
			sck_d <= sck_s;
			si_m <= si;
			si_s <= si_m;
			wp_m <= wp_n;
			wp_s <= wp_m;
		end
	end

	// Edges found by level compare, so a paused clock simply holds state
	assign selected = ~cs_s; // R1
	assign rise = selected & sck_s & ~sck_d; // R3 R4
	// A mode 3 frame opens with the clock high: no rise until it toggles
	assign fall = selected & ~sck_s & sck_d; // R9
	assign rx_byte = {shift_r, si_s}; // R5 R19
	assign byte_done = rise && (bit_cnt_r == 3'h7);
	assign status_byte = {protect_pin_enable_r, 3'h0, bp_r, wel_r, 1'b0};
	assign wr_ok = wel_r & ~lock_r; // R14 R20

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_cnt_r <= 3'h0;
			shift_r <= 7'h00;
		end else if (!selected) begin
			bit_cnt_r <= 3'h0;
		end else if (rise) begin // R5
			bit_cnt_r <= bit_cnt_r + 3'h1; // R10
			shift_r <= rx_byte[6:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_OPC;
			opc_r <= 8'h00;
			addr_cnt_r <= 2'h0;
			addr_r <= '0;
			space_r <= SP_MAIN;
			load_pend_r <= 1'b0;
		end else if (!selected) begin
			state_r <= ST_OPC; // R2
			load_pend_r <= 1'b0;
		end else if (byte_done) begin
			load_pend_r <= 1'b0;
			case (state_r)
				ST_OPC: begin // R17
					opc_r <= rx_byte;
					addr_cnt_r <= 2'h0;
					addr_r <= '0;
					case (rx_byte)
						OP_READ, OP_WRITE: begin
							space_r <= SP_MAIN;
							state_r <= ST_ADDR;
						end
						OP_SSRD, OP_SSWR: begin // R12
							space_r <= SP_SPECIAL;
							state_r <= ST_ADDR;
						end
						OP_WRSN: begin // R13
							space_r <= SP_SERIAL;
							state_r <= ST_WR;
						end
						// Serial number, ID and status reads use the serial space; RDID, RUID and RDSR only for its 8-byte index wrap
						OP_RDSN, OP_RDID, OP_RUID, OP_RDSR: begin
							space_r <= SP_SERIAL;
							state_r <= ST_RD;
							load_pend_r <= 1'b1;
						end
						OP_WRSR: state_r <= ST_WRSR;
						OP_WREN, OP_WRITE_DISABLE_CMD: state_r <= ST_DROP;
						default: state_r <= ST_DROP; // R18
					endcase
				end
				ST_ADDR: begin
					addr_r <= {addr_r[ADDR_W-9:0], rx_byte}; // R16
					addr_cnt_r <= addr_cnt_r + 2'h1;
					if (addr_cnt_r == 2'(ADDR_BYTES - 1)) begin
						if (opc_r == OP_READ || opc_r == OP_SSRD) begin
							state_r <= ST_RD;
							load_pend_r <= 1'b1;
						end else begin
							state_r <= ST_WR;
						end
					end
				end
				// Step the address a cycle late so the pending write still sees it
				ST_WR: load_pend_r <= 1'b1;
				ST_RD: load_pend_r <= 1'b1;
				ST_WRSR: state_r <= ST_DROP;
				default: state_r <= ST_DROP; // R18
			endcase
		end else if (load_pend_r) begin
			load_pend_r <= 1'b0;
			addr_r <= next_addr(addr_r, space_r);
		end
	end

	// Byte lands in storage one pclk after its last bit, long before the next
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_we_r <= 1'b0;
			mem_wdata_r <= 8'h00;
			wr_cnt_r <= 32'h0;
		end else begin
			mem_we_r <= byte_done && state_r == ST_WR && wr_ok
				&& !(space_r == SP_MAIN && is_protected(addr_r, bp_r)); // R8 R11
			mem_wdata_r <= rx_byte;
			if (mem_we_r) begin
				wr_cnt_r <= wr_cnt_r + 32'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wel_r <= 1'b0;
			protect_pin_enable_r <= 1'b0;
			bp_r <= BP_RST;
		end else if (byte_done && state_r == ST_OPC && rx_byte == OP_WREN) begin
			wel_r <= 1'b1;
		end else if (byte_done && state_r == ST_OPC && rx_byte == OP_WRITE_DISABLE_CMD) begin
			wel_r <= 1'b0; // R14 R20
		end else if (byte_done && state_r == ST_WRSR && wr_ok
			&& !(protect_pin_enable_r && !wp_s)) begin // R7
			protect_pin_enable_r <= rx_byte[ST_PROTECT_PIN_ENABLE_BIT];
			bp_r <= rx_byte[ST_BP_LSB +: 2]; // R11
		end
	end

	always_comb begin
		case (opc_r)
			OP_RDSR: tx_src = status_byte;
			OP_RDID: tx_src = DEV_ID[8 * (3 - int'(addr_r[1:0])) +: 8]; // R13
			OP_RUID: tx_src = UNIQUE_ID[8 * (7 - int'(addr_r[2:0])) +: 8];
			default: tx_src = mif.rdata;
		endcase
	end

	// Output changes only on falls, enable only in read data phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_r <= 8'h00;
			so <= 1'b0;
			so_oe_n <= 1'b1;
		end else if (!selected) begin
			so_oe_n <= 1'b1; // R1
		end else if (load_pend_r) begin
			tx_r <= tx_src;
		end else if (fall && state_r == ST_RD) begin // R3 R6 R15
			so <= tx_r[7]; // R19
			tx_r <= {tx_r[6:0], 1'b0};
			so_oe_n <= 1'b0;
		end
	end

	// APB slave: one wait state, unmapped addresses answer with an error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
			lock_r <= 1'b0;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			case (paddr)
				REG_CTRL: begin
					prdata <= {31'h0, lock_r};
					if (pwrite && pstrb[0]) begin
						lock_r <= pwdata[CTRL_LOCK_BIT];
					end
				end
				REG_STAT: prdata <= {23'h0, selected, status_byte};
				REG_WRCNT: prdata <= wr_cnt_r;
				default: pslverr <= 1'b1;
			endcase
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end
endmodule

// File: sfs_monitor.sv
/* Checker for sfs_slave, bound to its ports.
 Assumes one pclk domain, presetn asynchronous active low. */
`timescale 1ns/1ns
module sfs_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [sfs_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic so,
	input wire logic so_oe_n
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire mapped = paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008;
	sequence apb_access;
		psel && !penable ##1 psel && penable;
	endsequence
	chk_apb_wait: assert property (apb_access |=> pready)
		else $error("pready late");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held");
	chk_err_unmapped: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
		else $error("unmapped read not refused");
	chk_err_mapped: assert property (pready && mapped |-> !pslverr)
		else $error("mapped access refused");
	chk_idle_quiet: assert property (cs_n [*5] |-> so_oe_n)
		else $error("output driven while deselected");
	chk_oe_needs_sel: assert property (!so_oe_n |-> !$past(cs_n, 4))
		else $error("output driven without select");
	chk_oe_on_fall: assert property ($fell(so_oe_n) |-> !sck && !$past(sck, 2) && !cs_n)
		else $error("output enabled off a clock fall");
	chk_so_on_fall: assert property (!so_oe_n && $changed(so) |-> !sck && !$past(sck, 2))
		else $error("output changed off a clock fall");
endmodule
bind sfs_slave sfs_monitor mon_u (.pclk, .presetn, .psel, .penable, .paddr, .prdata,
	.pready, .pslverr, .cs_n, .sck, .so, .so_oe_n);

// File: sfs_spi_master.sv
/* SPI master model driving the memory front end.
 Pins move just after pclk rises; serial clock period 64 ns, modes 0 and 3. */
`timescale 1ns/1ns
module sfs_spi_master (
	input wire logic pclk,
	output logic cs_n,
	output logic sck,
	output logic si,
	input wire logic so,
	input wire logic so_oe_n
);
	logic [7:0] tx_q[$];
	logic [7:0] rx_q[$];
	int oe_bits;
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end
	task automatic run(input bit mode3);
		logic [7:0] b;
		rx_q = {};
		oe_bits = 0;
		sck <= mode3;
		repeat (4) @(posedge pclk);
		cs_n <= 1'b0;
		repeat (4) @(posedge pclk);
		foreach (tx_q[k]) begin
			for (int i = 7; i >= 0; i--) begin
				sck <= 1'b0;
				si <= tx_q[k][i];
				repeat (4) @(posedge pclk);
				sck <= 1'b1;
				// Sample mid high phase, where the output cannot move
				repeat (2) @(posedge pclk);
				// A released line reads as the opposite of the last bit
				b[i] = so_oe_n ? ~so : so;
				oe_bits += int'(!so_oe_n);
				repeat (2) @(posedge pclk);
			end
			rx_q.push_back(b);
			repeat (k * 5) @(posedge pclk);
		end
		sck <= mode3;
		repeat (4) @(posedge pclk);
		cs_n <= 1'b1;
		// Released line must not keep the last bit
		si <= ~si;
		repeat (6) @(posedge pclk);
	endtask
endmodule

// File: test_spi_fram_slave_interface.sv
/* Self-checking bench for sfs_slave with a byte model of memory and status.
 Assumes sfs_spi_master on the serial pins and APB driven from here. */
`timescale 1ns/1ns
module test_spi_fram_slave_interface;
	import sfs_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, wp_n, pready, pslverr, err;
	logic cs_n, sck, si, so, so_oe_n;
	logic [APB_AW-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [7:0] mem[int];
	logic [7:0] d[4];
	logic [23:0] a;
	int fails, checked, seed, wrcnt;
	logic [7:0] sq[$];
	localparam logic [31:0] ID_VAL = 32'h7e41_c902; // arbitrary value
	localparam logic [63:0] UID_VAL = 64'h1d2c_3b4a_5968_7786; // arbitrary value
	sfs_slave #(.DEPTH(1024), .DEV_ID(ID_VAL), .UNIQUE_ID(UID_VAL)) dut_u (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .cs_n, .sck, .si, .wp_n, .so, .so_oe_n);
	sfs_spi_master m_u (.pclk, .cs_n, .sck, .si, .so, .so_oe_n);
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("Counts: %0d checked, %0d failed", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			fails++;
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic spi(input bit m3, input logic [7:0] q[$]);
		m_u.tx_q = q;
		m_u.run(m3);
	endtask
	task automatic rdchk(input bit m3);
		spi(m3, {OP_READ, a[23:16], a[15:8], a[7:0], 8'h0, 8'h0, 8'h0, 8'h0});
		for (int k = 0; k < 4; k++)
			check(m_u.rx_q[k + 4], mem[int'(a[18:0]) + k]);
	endtask
	task automatic status(input logic [7:0] exp);
		spi(0, {OP_RDSR, 8'h0});
		check(m_u.rx_q[1], exp);
	endtask
	initial begin
		seed = 32'h6d66235f;
		{presetn, psel, penable, pwrite, paddr, pwdata, err} = '0;
		pstrb = 4'h1;
		wp_n = 1'b1;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, REG_STAT, 0);
		check(rd, 0);
		apb(0, 12'h00c, 0);
		check(err, 1);
		check(rd, 0);
		$display("register test done");
		for (int m = 0; m < 2; m++) begin
			a = 24'hf80000 | 24'($random(seed) & 32'h3f0);
			foreach (d[k]) d[k] = 8'($random(seed));
			spi(m, {OP_WREN});
			spi(m, {OP_WRITE, a[23:16], a[15:8], a[7:0], d[0], d[1], d[2], d[3]});
			foreach (d[k]) mem[int'(a[18:0]) + k] = d[k];
			wrcnt += 4;
			rdchk(!m);
		end
		apb(1, REG_CTRL, 1);
		spi(0, {OP_WRITE, a[23:16], a[15:8], a[7:0], ~d[0]});
		apb(1, REG_CTRL, 0);
		spi(1, {OP_WRITE_DISABLE_CMD});
		spi(1, {OP_WRITE, a[23:16], a[15:8], a[7:0], ~d[0]});
		rdchk(0);
		apb(0, REG_WRCNT, 0);
		check(rd, wrcnt);
		$display("memory test done");
		spi(0, {8'hff, OP_READ, 8'h0, 8'h0, 8'h0, 8'h0});
		check(m_u.oe_bits, 0);
		spi(0, {OP_WREN});
		spi(0, {OP_WRSR, 8'h80});
		status(8'h82);
		wp_n <= 1'b0;
		spi(0, {OP_WRSR, 8'h00});
		status(8'h82);
		apb(0, REG_STAT, 0);
		check(rd[7:0], 8'h82);
		wp_n <= 1'b1;
		spi(0, {OP_WRSR, 8'h0c});
		status(8'h0e);
		spi(0, {OP_WRITE, a[23:16], a[15:8], a[7:0], ~d[0]});
		rdchk(1);
		$display("status test done");
		foreach (d[k]) d[k] = 8'($random(seed));
		spi(1, {OP_SSWR, 8'h0, 8'h0, a[7:0], d[0], d[1], d[2], d[3]});
		spi(0, {OP_SSRD, 8'h0, 8'h0, a[7:0], 8'h0, 8'h0, 8'h0, 8'h0});
		for (int k = 0; k < 4; k++)
			check(m_u.rx_q[k + 4], d[k]);
		sq = {OP_WRSN};
		foreach (d[k]) sq.push_back(d[k]);
		foreach (d[k]) sq.push_back(~d[k]);
		spi(0, sq);
		spi(1, {OP_RDSN, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0});
		for (int k = 1; k < 9; k++)
			check(m_u.rx_q[k], sq[k]);
		wrcnt += 12;
		spi(0, {OP_RDID, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0});
		for (int k = 0; k < 5; k++)
			check(m_u.rx_q[k + 1], ID_VAL[8 * (3 - k % 4) +: 8]);
		spi(1, {OP_RUID, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0});
		for (int k = 0; k < 8; k++)
			check(m_u.rx_q[k + 1], UID_VAL[8 * (7 - k) +: 8]);
		apb(0, REG_WRCNT, 0);
		check(rd, wrcnt);
		$display("id test done");
		complete_run();
	end
	initial begin
		repeat (100000) @(posedge pclk);
		fails++;
		complete_run();
	end
endmodule
